// ### common/trs_defs.svh
// constants for the target responder: packet codes, match flags, layout
// assumes the receive stream carries the base-address match flags in user bits
`ifndef TRS_DEFS_SVH
`define TRS_DEFS_SVH
// fmt/type codes, header dword 0 bits 30..24
`define TRS_MRD32 7'h00
`define TRS_MRD64 7'h20
`define TRS_MWR32 7'h40
`define TRS_MWR64 7'h60
`define TRS_IORD 7'h02
`define TRS_IOWR 7'h42
`define TRS_CPL 7'h0A
`define TRS_CPLD 7'h4A
// match flag position in the receive user sideband
`define TRS_BAR_LSB 2
`define TRS_BAR_IO 0
`define TRS_BAR_M64 1
`define TRS_BAR_M32 2
`define TRS_BAR_ROM 6
// region numbers inside the shared word array
`define TRS_RGN_IO 2'h0
`define TRS_RGN_M32 2'h1
`define TRS_RGN_M64 2'h2
`define TRS_RGN_ROM 2'h3
`define TRS_REGION_BYTES 2048
`define TRS_REGION_WORDS 512
`define TRS_HDR_DWS 8
`define TRS_CPL_OK 3'h0
`endif

// ### common/trs_pkg.sv
// types shared by the target responder and its completion buffer
// assumes trs_defs.svh is on the include path
package trs_pkg;
`include "trs_defs.svh"
    // control sequence of the receive side
    typedef enum logic [1:0] {
        TRS_ST_RX,
        TRS_ST_DECODE,
        TRS_ST_CPL
    } trs_state_t;
    // one completion packet: dword count and up to four dwords, dword 0 low
    typedef struct packed {
        logic [2:0]   ndw;
        logic [127:0] dws;
    } trs_cpl_t;
endpackage : trs_pkg

// ### rtl/trs_pair_buffer.sv
// small valid/ready buffer holding whole completion packets
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps
module trs_pair_buffer #(
    parameter int WIDTH = 131,
    parameter int DEPTH = 2
) (
    input  wire logic             I_CLK,
    input  wire logic             I_RESET,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic [WIDTH-1:0]      o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
        $error("buffer needs at least two entries");
    end
    logic [WIDTH-1:0] slot_reg [0:DEPTH-1];
    logic [PW-1:0]    wr_reg;
    logic [PW-1:0]    rd_reg;
    logic [PW:0]      cnt_reg;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;
    wire [PW-1:0]     wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    wire [PW-1:0]     rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    // full and empty straight from the count, so a stalled drain backs up
    assign o_in_ready  = cnt_reg != (PW+1)'(DEPTH);
    assign o_out_valid = cnt_reg != '0;
    assign o_out_data  = slot_reg[rd_reg];
    // storage needs no reset, only the pointers and the count do
    always_ff @(posedge I_CLK) begin
        if (push) begin
            slot_reg[wr_reg] <= i_in_data;
        end
    end
    // pointers and occupancy
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_next;
            if (pop) rd_reg <= rd_next;
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : trs_pair_buffer

// ### rtl/trs_target_responder.sv
// target-only responder behind an endpoint core's transaction stream
// assumes stream inputs come from logic on I_CLK; no synchronisers needed
`timescale 1ns/1ps
`include "trs_defs.svh"
module trs_target_responder #(
    parameter int DATA_W    = 64,
    parameter int TUSER_W   = 22,
    parameter bit IO_ENABLE = 1'b0
) (
    input  wire logic                I_CLK,
    input  wire logic                I_RESET,
    input  wire logic [DATA_W-1:0]   I_RX_TDATA,
    input  wire logic                I_RX_TLAST,
    input  wire logic                I_RX_TVALID,
    input  wire logic [TUSER_W-1:0]  I_RX_TUSER,
    output logic                     O_RX_TREADY,
    output logic [DATA_W-1:0]        O_TX_TDATA,
    output logic [DATA_W/8-1:0]      O_TX_TKEEP,
    output logic                     O_TX_TLAST,
    output logic                     O_TX_TVALID,
    input  wire logic                I_TX_TREADY,
    input  wire logic [15:0]         I_CPL_ID
);
    import trs_pkg::*;
    localparam int NL = DATA_W / 32;
    localparam int AW = $clog2(4 * `TRS_REGION_WORDS);
    // three datapath widths only
    if ((DATA_W != 32 && DATA_W != 64 && DATA_W != 128) || TUSER_W < 10) begin : g_bad
        $error("stream width must be 32, 64 or 128");
    end

    // region pick from match flags, {valid, region}
    function automatic logic [2:0] region_of(input logic [7:0] hit, input logic io);
        if (io)
            region_of = {hit[`TRS_BAR_IO] && IO_ENABLE, `TRS_RGN_IO};
        else if (hit[`TRS_BAR_M64])
            region_of = {1'b1, `TRS_RGN_M64};
        else if (hit[`TRS_BAR_M32])
            region_of = {1'b1, `TRS_RGN_M32};
        else
            region_of = {hit[`TRS_BAR_ROM], `TRS_RGN_ROM};
    endfunction : region_of

    function automatic logic [11:0] byte_count(input logic [3:0] be);
        casez (be)
            4'b1??1: byte_count = 12'h004;
            4'b01?1, 4'b1?10: byte_count = 12'h003;
            4'b0011, 4'b0110, 4'b1100: byte_count = 12'h002;
            default: byte_count = 12'h001;
        endcase
    endfunction : byte_count

    trs_state_t  state_reg;
    trs_state_t  state_next;
    logic        buf_in_ready;
    logic [3:0]  idx_reg;
    logic        sop_reg;
    logic [7:0]  bar_reg;
    logic [31:0] rd_reg;
    logic [31:0] mem [0:4*`TRS_REGION_WORDS-1]; // all four regions
    wire  [255:0] hdr;
    wire         rx_fire = I_RX_TVALID && O_RX_TREADY;

    // receive is open only while idle, so writes stall the stream
    assign O_RX_TREADY = state_reg == TRS_ST_RX;

    // gather up to eight dwords, later lanes of a long packet fall away
    for (genvar g = 0; g < `TRS_HDR_DWS; g++) begin : g_hdr
        logic [31:0] word_reg;
        wire  [3:0]  lane = 4'(g) - idx_reg;
        assign hdr[32*g +: 32] = word_reg;
        always_ff @(posedge I_CLK) begin
            if (rx_fire && 4'(g) >= idx_reg && lane < 4'(NL)) word_reg <= I_RX_TDATA[32*lane[1:0] +: 32];
        end
    end

    // header field decode
    wire [31:0] dw0 = hdr[31:0];
    wire [31:0] dw1 = hdr[63:32];
    wire [6:0]  ftype = dw0[30:24];
    wire        is4 = dw0[29];
    wire        len_ok = dw0[9:0] == 10'h001;
    wire [31:0] addr = is4 ? hdr[127:96] : hdr[95:64];
    wire [31:0] wdata = is4 ? hdr[159:128] : hdr[127:96];
    wire [3:0]  first_be = dw1[3:0];
    wire        is_io = ftype == `TRS_IORD || ftype == `TRS_IOWR;
    wire        is_rd = ftype == `TRS_MRD32 || ftype == `TRS_MRD64 || ftype == `TRS_IORD;
    wire        is_wr = ftype == `TRS_MWR32 || ftype == `TRS_MWR64 || ftype == `TRS_IOWR;
    wire [2:0]  rgn = region_of(bar_reg, is_io);
    wire        accept = len_ok && (is_rd || is_wr) && rgn[2]; // long ones dropped
    wire [AW-1:0] widx = {rgn[1:0], addr[10:2]}; // bits above 2 KB ignored, so wrap
    wire        in_decode = state_reg == TRS_ST_DECODE;

    // sequence: gather, decode and act, then hand a completion over
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TRS_ST_RX: if (rx_fire && I_RX_TLAST) state_next = TRS_ST_DECODE;
            TRS_ST_DECODE: begin
                if (accept && (is_rd || ftype == `TRS_IOWR)) state_next = TRS_ST_CPL;
                else state_next = TRS_ST_RX; // no completion for memory writes
            end
            TRS_ST_CPL: if (buf_in_ready) state_next = TRS_ST_RX;
            default: state_next = TRS_ST_RX;
        endcase
    end

    // control state; flags taken on the first beat of each packet
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state_reg <= TRS_ST_RX;
            idx_reg   <= '0;
            sop_reg   <= 1'b1;
            bar_reg   <= '0;
        end else begin
            state_reg <= state_next;
            if (rx_fire && sop_reg) bar_reg <= I_RX_TUSER[`TRS_BAR_LSB +: 8];
            if (rx_fire) sop_reg <= I_RX_TLAST;
            if (state_reg != TRS_ST_RX) idx_reg <= '0;
            else if (rx_fire && !I_RX_TLAST && idx_reg < 4'(`TRS_HDR_DWS)) idx_reg <= idx_reg + 4'(NL);
        end
    end

    // word array: byte-enabled write and registered read, one per decode
    always_ff @(posedge I_CLK) begin
        if (in_decode && accept && is_wr) begin
            for (int b = 0; b < 4; b++) begin
                if (first_be[b]) mem[widx][8*b +: 8] <= wdata[8*b +: 8];
            end
        end
        if (in_decode && accept && is_rd) rd_reg <= mem[widx];
    end

    // completion assembly from the held request header
    trs_cpl_t   cpl;
    wire        with_data = is_rd;
    wire [1:0]  lo = first_be[0] ? 2'h0 : first_be[1] ? 2'h1 : first_be[2] ? 2'h2 : first_be[3] ? 2'h3 : 2'h0;
    wire [11:0] bc = is_io ? 12'h004 : byte_count(first_be);
    wire [6:0]  low_addr = is_io ? 7'h00 : {addr[6:2], lo};
    assign cpl.ndw = with_data ? 3'h4 : 3'h3;
    assign cpl.dws[31:0] = {1'b0, with_data ? `TRS_CPLD : `TRS_CPL, 1'b0, dw0[22:20], 6'h00,
                           dw0[13:12], 2'h0, 9'h000, with_data};
    assign cpl.dws[63:32] = {I_CPL_ID, `TRS_CPL_OK, 1'b0, bc}; // success status
    assign cpl.dws[95:64] = {dw1[31:8], 1'b0, low_addr};
    assign cpl.dws[127:96] = with_data ? rd_reg : 32'h0000_0000;

    // two-entry buffer so a stalled transmit side loses no completion
    wire        buf_in_valid = state_reg == TRS_ST_CPL; // only after a request
    trs_cpl_t   buf_out;
    logic       buf_out_valid;
    logic [1:0] beat_reg;
    wire [3:0]  sent_dws = 4'((beat_reg + 3'd1) * NL);
    wire        tx_last = sent_dws >= {1'b0, buf_out.ndw};
    wire [127:0] tx_shift = buf_out.dws >> (DATA_W * beat_reg);

    trs_pair_buffer #(
        .WIDTH ($bits(trs_cpl_t)),
        .DEPTH (2)
    ) u_cpl_buf (
        .I_CLK       (I_CLK),
        .I_RESET     (I_RESET),
        .i_in_data   (cpl),
        .i_in_valid  (buf_in_valid),
        .o_in_ready  (buf_in_ready),
        .o_out_data  (buf_out),
        .o_out_valid (buf_out_valid),
        .i_out_ready (I_TX_TREADY && tx_last)
    );

    // serialise a buffered completion, NL dwords per beat
    assign O_TX_TVALID = buf_out_valid;
    assign O_TX_TLAST  = tx_last;
    assign O_TX_TDATA  = tx_shift[DATA_W-1:0];
    for (genvar k = 0; k < NL; k++) begin : g_keep
        wire [3:0] dw_no = 4'(beat_reg * NL + k);
        assign O_TX_TKEEP[4*k +: 4] = (dw_no < {1'b0, buf_out.ndw}) ? 4'hF : 4'h0;
    end

    // beat counter returns to zero at every packet end
    always_ff @(posedge I_CLK) begin
        if (I_RESET) beat_reg <= '0;
        else if (O_TX_TVALID && I_TX_TREADY) beat_reg <= tx_last ? 2'h0 : beat_reg + 2'h1;
    end

    // checks on the design's own behaviour
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    AST_STALL_AFTER_LAST: assert property (rx_fire && I_RX_TLAST |=> in_decode && !O_RX_TREADY)
        else $error("receive ready not dropped after packet end");
    AST_WRITE_STORES: assert property (in_decode && accept && is_wr && first_be == 4'hF
        |=> mem[$past(widx)] == $past(wdata))
        else $error("write payload not stored");
    AST_MWR_NO_CPL: assert property (in_decode && accept && is_wr && !is_io |=> O_RX_TREADY)
        else $error("memory write did not return to receive");
    AST_IOWR_CPL: assert property (in_decode && accept && ftype == `TRS_IOWR
        |=> buf_in_valid && cpl.ndw == 3'h3 && cpl.dws[47:45] == `TRS_CPL_OK)
        else $error("io write lacks success completion");
    AST_READ_ONE_DW: assert property (in_decode && accept && is_rd
        |=> buf_in_valid && cpl.ndw == 3'h4 && cpl.dws[127:96] == mem[$past(widx)])
        else $error("read completion data wrong");
    AST_LONG_DROPPED: assert property (in_decode && !len_ok |=> O_RX_TREADY && !buf_in_valid)
        else $error("long request not dropped");
    AST_IO_OFF: assert property (in_decode && is_io && !(IO_ENABLE && bar_reg[`TRS_BAR_IO])
        |=> !buf_in_valid)
        else $error("io region answered while disabled");
    AST_CPL_IDS: assert property (buf_in_valid |-> cpl.dws[95:72] == dw1[31:8]
        && cpl.dws[22:20] == dw0[22:20] && cpl.dws[13:12] == dw0[13:12])
        else $error("completion identity not copied");
    AST_ONLY_ANSWERS: assert property ($rose(buf_in_valid) |-> $past(in_decode) && $past(accept))
        else $error("completion without a request");
    AST_TX_HOLD: assert property (O_TX_TVALID && !I_TX_TREADY |=> O_TX_TVALID && $stable(O_TX_TDATA))
        else $error("transmit beat changed while stalled");

    COV_READ: cover property (in_decode && accept && is_rd ##1 buf_in_valid);
    COV_IOWR: cover property (in_decode && accept && ftype == `TRS_IOWR);
    COV_LONG: cover property (in_decode && !len_ok);
    COV_TX_STALL: cover property (O_TX_TVALID && !I_TX_TREADY ##1 O_TX_TVALID && I_TX_TREADY);
endmodule : trs_target_responder

// ### tb/trs_core_model.sv
// endpoint core stream model: feeds request packets, collects completions
// assumes a 64-bit stream and a 22-bit receive user sideband
`timescale 1ns/1ps
module trs_core_model (
    input  wire logic        I_CLK,
    output logic [63:0]      O_RX_TDATA,
    output logic             O_RX_TLAST,
    output logic             O_RX_TVALID,
    output logic [21:0]      O_RX_TUSER,
    input  wire logic        I_RX_TREADY,
    input  wire logic [63:0] I_TX_TDATA,
    input  wire logic [7:0]  I_TX_TKEEP,
    input  wire logic        I_TX_TLAST,
    input  wire logic        I_TX_TVALID,
    output logic             O_TX_TREADY
);
    logic [31:0] dq[$];
    int          plen[$];
    int          cnt = 0;
    int          hang = 0;
    bit          stall = 1'b0;
    // quiet stream at time zero
    initial begin
        O_RX_TDATA = 64'h0;
        O_RX_TLAST = 1'b0;
        O_RX_TVALID = 1'b0;
        O_RX_TUSER = 22'h0;
        O_TX_TREADY = 1'b0;
    end
    // one packet, two dwords a beat; each beat held until ready is sampled high
    task automatic send(input logic [31:0] d [8], input int n, input logic [7:0] fl);
        int w;
        for (int i = 0; i < n; i += 2) begin
            @(negedge I_CLK);
            O_RX_TDATA <= {d[i+1], d[i]};
            O_RX_TLAST <= (i + 2 >= n);
            O_RX_TVALID <= 1'b1;
            O_RX_TUSER <= {12'h000, fl, 2'h0};
            w = 0;
            do begin
                @(posedge I_CLK);
                w++;
            end while (I_RX_TREADY !== 1'b1 && w < 200);
            if (I_RX_TREADY !== 1'b1) hang++;
        end
        // released lines flip so stale data never looks valid
        @(negedge I_CLK);
        O_RX_TVALID <= 1'b0;
        O_RX_TDATA <= ~O_RX_TDATA;
        O_RX_TUSER <= ~O_RX_TUSER;
    endtask : send
    // ready follows the stall knob, so the host can answer slowly
    always @(negedge I_CLK) O_TX_TREADY <= !stall;
    // gather completion dwords lane by lane, one length entry per packet
    always @(posedge I_CLK) begin
        if (I_TX_TVALID === 1'b1 && O_TX_TREADY) begin
            for (int k = 0; k < 2; k++) begin
                if (I_TX_TKEEP[4*k] === 1'b1) begin
                    dq.push_back(I_TX_TDATA[32*k+:32]);
                    cnt++;
                end
            end
            if (I_TX_TLAST === 1'b1) begin
                plen.push_back(cnt);
                cnt = 0;
            end
        end
    end
endmodule : trs_core_model

// ### tb/trs_target_responder_tb_top.sv
// self-checking bench: responder between the stream model and scenario tasks
// assumes the 64-bit stream build with io space switched on
`timescale 1ns/1ps
`include "trs_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] t=%0t got %h want %h", $time, a, b); end end
module trs_target_responder_tb_top;
    localparam logic [2:0]  TC = 3'h5;
    localparam logic [1:0]  ATTR = 2'h2;
    localparam logic [15:0] RID = 16'hBEEF;
    localparam logic [15:0] CPL_ID = 16'h0A5C;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [63:0] rx_data;
    logic        rx_last;
    logic        rx_valid;
    logic [21:0] rx_user;
    logic        rx_ready;
    logic [63:0] tx_data;
    logic [7:0]  tx_keep;
    logic        tx_last;
    logic        tx_valid;
    logic        tx_ready;
    int          err_total = 0;
    int          check_count = 0;
    always #2 clk = ~clk;
    trs_target_responder #(.DATA_W(64), .TUSER_W(22), .IO_ENABLE(1'b1)) i_trs_target_responder (
        .I_CLK(clk), .I_RESET(rst), .I_RX_TDATA(rx_data), .I_RX_TLAST(rx_last), .I_RX_TVALID(rx_valid),
        .I_RX_TUSER(rx_user), .O_RX_TREADY(rx_ready), .O_TX_TDATA(tx_data), .O_TX_TKEEP(tx_keep),
        .O_TX_TLAST(tx_last), .O_TX_TVALID(tx_valid), .I_TX_TREADY(tx_ready), .I_CPL_ID(CPL_ID));
    trs_core_model i_trs_core_model (
        .I_CLK(clk), .O_RX_TDATA(rx_data), .O_RX_TLAST(rx_last), .O_RX_TVALID(rx_valid),
        .O_RX_TUSER(rx_user), .I_RX_TREADY(rx_ready), .I_TX_TDATA(tx_data), .I_TX_TKEEP(tx_keep),
        .I_TX_TLAST(tx_last), .I_TX_TVALID(tx_valid), .O_TX_TREADY(tx_ready));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // build one request; 4dw header when the 64-bit address bit is set
    task automatic req(input logic [6:0] ty, input logic [31:0] a, input logic [31:0] v,
                       input logic [9:0] len, input logic [7:0] fl, input logic [7:0] tag);
        logic [31:0] d [8];
        int          h;
        h = ty[5] ? 4 : 3;
        d[0] = {1'b0, ty, 1'b0, TC, 6'h00, ATTR, 2'h0, len};
        d[1] = {RID, tag, 8'h0F};
        d[2] = 32'h0000_0001;
        d[h-1] = a;
        for (int k = 0; k < 4; k++) d[h+k] = v + k;
        i_trs_core_model.send(d, ty[6] ? h + len : h, fl);
        if (i_trs_core_model.hang != 0) begin
            err_total++;
            $display("[ERR] t=%0t receive stream stuck", $time);
            give_verdict();
        end
    endtask : req
    // expected completion worked out from the request that caused it
    task automatic chk_cpl(input logic [7:0] tag, input logic [31:0] a, input logic [31:0] v,
                           input logic dat, input logic io);
        logic [31:0] c [4];
        int          w;
        int          n;
        w = 0;
        while (i_trs_core_model.plen.size() == 0 && w < 300) begin
            @(negedge clk);
            w++;
        end
        if (w >= 300) begin
            err_total++;
            $display("[ERR] t=%0t no completion", $time);
            give_verdict();
        end
        n = i_trs_core_model.plen.pop_front();
        for (int k = 0; k < n; k++) c[k] = i_trs_core_model.dq.pop_front();
        `CHK(n, dat ? 4 : 3)
        `CHK(c[0], {1'b0, dat ? `TRS_CPLD : `TRS_CPL, 1'b0, TC, 6'h00, ATTR, 2'h0, 9'h000, dat})
        `CHK(c[1], {CPL_ID, `TRS_CPL_OK, 1'b0, 12'h004})
        `CHK(c[2], {RID, tag, 1'b0, io ? 7'h00 : {a[6:2], 2'h0}})
        if (dat) `CHK(c[3], v)
    endtask : chk_cpl
    // nothing may come back for a while
    task automatic noc;
        repeat (16) @(negedge clk);
        `CHK(i_trs_core_model.plen.size(), 0)
    endtask : noc
    task automatic t_mem32;
        req(`TRS_MWR32, 32'h10, 32'hA5A5_0001, 10'h001, 8'h04, 8'h01);
        `CHK(rx_ready, 1'b0)
        noc();
        req(`TRS_MRD32, 32'h10, 32'h0, 10'h001, 8'h04, 8'h02);
        chk_cpl(8'h02, 32'h10, 32'hA5A5_0001, 1'b1, 1'b0);
        $display("test mem32 done");
    endtask : t_mem32
    // offset 4 in mem32 and mem64 plus the top rom word, mem64 reached above 2 KB
    task automatic t_regions;
        req(`TRS_MWR32, 32'h4, 32'h3333_0004, 10'h001, 8'h04, 8'h03);
        req(`TRS_MWR64, 32'h804, 32'h6464_0804, 10'h001, 8'h02, 8'h04);
        req(`TRS_MWR32, 32'h7FC, 32'h7070_07FC, 10'h001, 8'h40, 8'h05);
        req(`TRS_MRD64, 32'h4, 32'h0, 10'h001, 8'h02, 8'h06);
        chk_cpl(8'h06, 32'h4, 32'h6464_0804, 1'b1, 1'b0);
        req(`TRS_MRD32, 32'h4, 32'h0, 10'h001, 8'h04, 8'h07);
        chk_cpl(8'h07, 32'h4, 32'h3333_0004, 1'b1, 1'b0);
        req(`TRS_MRD32, 32'h7FC, 32'h0, 10'h001, 8'h40, 8'h08);
        chk_cpl(8'h08, 32'h7FC, 32'h7070_07FC, 1'b1, 1'b0);
        $display("test regions done");
    endtask : t_regions
    task automatic t_io;
        req(`TRS_IOWR, 32'h20, 32'h1234_5678, 10'h001, 8'h01, 8'h09);
        chk_cpl(8'h09, 32'h20, 32'h0, 1'b0, 1'b1);
        req(`TRS_IOWR, 32'h20, 32'h0BAD_0BAD, 10'h001, 8'h04, 8'h0A);
        noc();
        req(`TRS_IORD, 32'h20, 32'h0, 10'h001, 8'h01, 8'h0B);
        chk_cpl(8'h0B, 32'h20, 32'h1234_5678, 1'b1, 1'b1);
        $display("test io done");
    endtask : t_io
    // longer packets are swallowed whole and leave memory alone
    task automatic t_drop;
        req(`TRS_MWR32, 32'h10, 32'h5A5A_0000, 10'h002, 8'h04, 8'h0C);
        req(`TRS_MRD32, 32'h10, 32'h0, 10'h002, 8'h04, 8'h0D);
        noc();
        req(`TRS_MRD32, 32'h10, 32'h0, 10'h001, 8'h04, 8'h0E);
        chk_cpl(8'h0E, 32'h10, 32'hA5A5_0001, 1'b1, 1'b0);
        $display("test drop done");
    endtask : t_drop
    // host stalls until the buffer refuses, then drains it in order
    task automatic t_stall;
        i_trs_core_model.stall = 1'b1;
        req(`TRS_MRD32, 32'h4, 32'h0, 10'h001, 8'h04, 8'h10);
        req(`TRS_MRD64, 32'h4, 32'h0, 10'h001, 8'h02, 8'h11);
        // third one finds the buffer full and holds the receive side
        req(`TRS_MRD32, 32'h7FC, 32'h0, 10'h001, 8'h40, 8'h12);
        repeat (10) @(negedge clk);
        `CHK(rx_ready, 1'b0)
        `CHK(tx_valid, 1'b1)
        i_trs_core_model.stall = 1'b0;
        chk_cpl(8'h10, 32'h4, 32'h3333_0004, 1'b1, 1'b0);
        chk_cpl(8'h11, 32'h4, 32'h6464_0804, 1'b1, 1'b0);
        chk_cpl(8'h12, 32'h7FC, 32'h7070_07FC, 1'b1, 1'b0);
        noc();
        $display("test stall done");
    endtask : t_stall
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        `CHK(tx_valid, 1'b0)
        t_mem32();
        t_regions();
        t_io();
        t_drop();
        t_stall();
        give_verdict();
    end
endmodule : trs_target_responder_tb_top
